// >>> core/e1_liu_tx_input_and_loopback.sv
// Operation
// - clocked mode samples marks on clock fall
// - local loop: transmit feeds own receiver
// - remote loop: received marks feed transmitter
// - both selects low: normal independent paths
// - both selects high: all line and receive outputs high-impedance
// - receive marks pulse per line polarity
// - loss flag high while signal lost
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "liu_consts.svh"
module e1_liu_tx_input_and_loopback
   import liu_pkg::*;
#(
   parameter int LOS_CYCLES = `LOS_CYC,
   parameter int PULSE_CYC  = `PULSE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   input  wire logic        tx_bit_clock,
   input  wire logic        tx_mark_plus,
   input  wire logic        tx_mark_minus,
   input  wire logic        near_loop_select,
   input  wire logic        far_loop_select,
   input  wire logic        line_in_a,
   input  wire logic        line_in_b,
   output logic             line_out_a,
   output logic             line_out_a_oe,
   output logic             line_out_b,
   output logic             line_out_b_oe,
   output logic             rx_mark_plus,
   output logic             rx_mark_plus_oe,
   output logic             rx_mark_minus,
   output logic             rx_mark_minus_oe,
   output logic             rx_signal_lost,
   output logic             rx_signal_lost_oe
);
   // ****************************************
   // pin synchronisers and pulse shapers
   // ****************************************
   liu_state_t  st_reg;
   liu_state_t  st_next;
   logic [6:0]  pins_s;
   logic        s_clk, s_plus, s_minus, s_near, s_far, s_lina, s_linb;
   logic        clk_fall, pin_p, pin_m, line_p, line_m;
   logic        rx_p_ev, rx_m_ev, tx_p_ev, tx_m_ev, rx_any;
   logic        tx_lvl_p, tx_lvl_m, rx_lvl_p, rx_lvl_m;
   logic        do_write, do_read;
   logic [2:0]  int_set, int_clr;
   logic [31:0] rd_mux;
   loop_mode_t  mode_in;

   mark_pair_if tx_ev_if();
   mark_pair_if rx_ev_if();

   pin_sync #(
      .W (7)
   ) u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .pin_in   ({line_in_b, line_in_a, far_loop_select, near_loop_select,
                  tx_mark_minus, tx_mark_plus, tx_bit_clock}),
      .pin_sync (pins_s)
   );

   assign {s_linb, s_lina, s_far, s_near, s_minus, s_plus, s_clk} = pins_s;

   pulse_stretch #(
      .CYC (PULSE_CYC)
   ) u_tx_pulse (
      .mclk        (mclk),
      .reset       (reset),
      .ev          (tx_ev_if.take),
      .level_plus  (tx_lvl_p),
      .level_minus (tx_lvl_m)
   );

   pulse_stretch #(
      .CYC (PULSE_CYC)
   ) u_rx_pulse (
      .mclk        (mclk),
      .reset       (reset),
      .ev          (rx_ev_if.take),
      .level_plus  (rx_lvl_p),
      .level_minus (rx_lvl_m)
   );

   // ****************************************
   // mark selection and loopback routing
   // ****************************************
   // both rails at once is no valid symbol; it is dropped
   always_comb begin
      clk_fall = st_reg.clk_prev & ~s_clk;
      if (st_reg.clockless) begin
         pin_p = s_plus & ~st_reg.plus_prev & ~s_minus;
         pin_m = s_minus & ~st_reg.minus_prev & ~s_plus;
      end else begin
         pin_p = clk_fall & s_plus & ~s_minus;
         pin_m = clk_fall & s_minus & ~s_plus;
      end
      line_p = s_lina & ~st_reg.lin_a_prev & ~s_linb;
      line_m = s_linb & ~st_reg.lin_b_prev & ~s_lina;
      case (st_reg.mode)
         MODE_LOCAL: begin
            rx_p_ev = pin_p;
            rx_m_ev = pin_m;
            tx_p_ev = pin_p;
            tx_m_ev = pin_m;
         end
         MODE_REMOTE: begin
            rx_p_ev = line_p;
            rx_m_ev = line_m;
            tx_p_ev = line_p;
            tx_m_ev = line_m;
         end
         default: begin
            rx_p_ev = line_p;
            rx_m_ev = line_m;
            tx_p_ev = pin_p;
            tx_m_ev = pin_m;
         end
      endcase
      rx_any = rx_p_ev | rx_m_ev;
   end

   assign tx_ev_if.plus  = tx_p_ev;
   assign tx_ev_if.minus = tx_m_ev;
   assign rx_ev_if.plus  = rx_p_ev;
   assign rx_ev_if.minus = rx_m_ev;
   assign mode_in        = loop_mode_t'({s_far, s_near});

   // ****************************************
   // register read mux
   // ****************************************
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `OFS_CTRL:       rd_mux[`CTRL_CLOCKLESS] = st_reg.clockless;
         `OFS_STATUS: begin
            rd_mux[`STAT_MODE_LSB +: 2] = st_reg.mode;
            rd_mux[`STAT_LOS]           = st_reg.los;
            rd_mux[`STAT_CLOCKLESS]     = st_reg.clockless;
         end
         `OFS_INT_STATUS: rd_mux[`INT_BITS-1:0] = st_reg.int_stat;
         `OFS_INT_MASK:   rd_mux[`INT_BITS-1:0] = st_reg.int_mask;
         `OFS_TX_COUNT:   rd_mux[15:0] = st_reg.tx_count;
         `OFS_RX_COUNT:   rd_mux[15:0] = st_reg.rx_count;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_next            = st_reg;
      st_next.clk_prev   = s_clk;
      st_next.plus_prev  = s_plus;
      st_next.minus_prev = s_minus;
      st_next.lin_a_prev = s_lina;
      st_next.lin_b_prev = s_linb;
      st_next.mode       = mode_in;
      // test mode releases every line and receive pin; it lags the mode register by one cycle
      st_next.oe         = (st_reg.mode != MODE_TEST);
      st_next.out_a      = tx_lvl_p;
      st_next.out_b      = tx_lvl_m;
      st_next.rx_p       = rx_lvl_p;
      st_next.rx_m       = rx_lvl_m;
      if (tx_p_ev | tx_m_ev) begin
         st_next.tx_count = st_reg.tx_count + 16'h0001;
      end
      if (rx_any) begin
         st_next.rx_count = st_reg.rx_count + 16'h0001;
      end

      // counting in clock cycles, so the limit is fixed in time and does not track the rate
      if (rx_any) begin
         st_next.los_cnt = 16'h0000;
         st_next.los     = 1'b0;
      end else if (st_reg.los_cnt != 16'(LOS_CYCLES)) begin
         st_next.los_cnt = st_reg.los_cnt + 16'h0001;
         if (st_next.los_cnt == 16'(LOS_CYCLES)) begin
            st_next.los = 1'b1;
         end
      end

      do_write = 1'b0;
      do_read  = 1'b0;
      case (st_reg.bus)
         BUS_IDLE: begin
            st_next.waitreq = 1'b1;
            if (avs_read | avs_write) begin
               st_next.bus     = BUS_ANSWER;
               st_next.waitreq = 1'b0;
               st_next.rdata   = rd_mux;
            end
         end
         BUS_ANSWER: begin
            st_next.bus     = BUS_IDLE;
            st_next.waitreq = 1'b1;
            do_write        = avs_write & avs_byteenable[0];
            do_read         = avs_read;
         end
         default: begin
            st_next.bus     = BUS_IDLE;
            st_next.waitreq = 1'b1;
         end
      endcase
      if (do_write && avs_address == `OFS_CTRL) begin
         st_next.clockless = avs_writedata[`CTRL_CLOCKLESS];
      end
      if (do_write && avs_address == `OFS_INT_MASK) begin
         st_next.int_mask = avs_writedata[`INT_BITS-1:0];
      end

      int_set                = '0;
      int_set[`INT_LOS_SET]  = st_next.los & ~st_reg.los;
      int_set[`INT_LOS_CLR]  = ~st_next.los & st_reg.los;
      int_set[`INT_MODE_CHG] = (mode_in != st_reg.mode);
      // only bits already returned are cleared, so an event after the snapshot survives
      int_clr                = (do_read && avs_address == `OFS_INT_STATUS) ?
                               st_reg.rdata[`INT_BITS-1:0] : 3'h0;
      st_next.int_stat       = (st_reg.int_stat & ~int_clr) | int_set;
      st_next.irq            = |(st_next.int_stat & st_next.int_mask);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg           <= '0;
         st_reg.los       <= 1'b1;
         st_reg.los_cnt   <= 16'(LOS_CYCLES);
         st_reg.oe        <= 1'b1;
         st_reg.waitreq   <= 1'b1;
         st_reg.clockless <= `CTRL_RESET;
         st_reg.int_mask  <= `INT_MASK_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign avs_readdata      = st_reg.rdata;
   assign avs_waitrequest   = st_reg.waitreq;
   assign irq               = st_reg.irq;
   assign line_out_a        = st_reg.out_a;
   assign line_out_b        = st_reg.out_b;
   assign rx_mark_plus      = st_reg.rx_p;
   assign rx_mark_minus     = st_reg.rx_m;
   assign rx_signal_lost    = st_reg.los;
   assign line_out_a_oe     = st_reg.oe;
   assign line_out_b_oe     = st_reg.oe;
   assign rx_mark_plus_oe   = st_reg.oe;
   assign rx_mark_minus_oe  = st_reg.oe;
   assign rx_signal_lost_oe = st_reg.oe;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   clk_capture_a: assert property (
      (!st_reg.clockless && st_reg.mode == MODE_NORMAL && clk_fall && s_plus && !s_minus)
      |-> ##2 line_out_a)
      else $error("clocked plus mark not sent");

   near_loop_a: assert property (
      (st_reg.mode == MODE_LOCAL && pin_m) |-> ##2 rx_mark_minus)
      else $error("local loop mark missing at receiver");

   far_loop_a: assert property (
      (st_reg.mode == MODE_REMOTE && line_p) |-> ##2 (line_out_a && rx_mark_plus))
      else $error("remote loop mark not retransmitted");

   far_ignore_a: assert property (
      (st_reg.mode == MODE_REMOTE && pin_p && !line_p) |-> !tx_ev_if.plus)
      else $error("terminal mark leaked in remote loop");

   normal_path_a: assert property (
      (st_reg.mode == MODE_NORMAL && pin_p && !line_p) |-> !rx_ev_if.plus)
      else $error("transmit mark looped in normal mode");

   test_hiz_a: assert property (
      (st_reg.mode == MODE_TEST)
      |=> !(line_out_a_oe || line_out_b_oe || rx_mark_plus_oe || rx_mark_minus_oe
            || rx_signal_lost_oe))
      else $error("pin driven in test mode");

   rx_pulse_a: assert property (
      rx_ev_if.plus |-> ##2 rx_mark_plus [*6])
      else $error("receive plus pulse too short");

   los_clear_a: assert property (
      rx_any |-> ##1 !rx_signal_lost)
      else $error("loss flag held despite mark");

   los_set_a: assert property (
      $rose(rx_signal_lost) |-> $past(st_reg.los_cnt) == 16'(LOS_CYCLES - 1))
      else $error("loss flag rose at wrong count");

   local_seen_c:  cover property (st_reg.mode == MODE_LOCAL && tx_p_ev);
   remote_seen_c: cover property (st_reg.mode == MODE_REMOTE && line_m);
   los_rise_c:    cover property ($rose(rx_signal_lost));
   test_mode_c:   cover property (st_reg.mode == MODE_TEST ##1 !line_out_a_oe);
endmodule

// >>> core/liu_consts.svh
`ifndef LIU_CONSTS_SVH
`define LIU_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   40
`define RX_PULSE_MIN_NS 210
`define PULSE_CYC       ((`RX_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_PERIOD_NS   488
`define LOS_ZERO_BITS   32
`define LOS_CYC         ((`LOS_ZERO_BITS * `BIT_PERIOD_NS) / `CLK_PERIOD_NS)

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_INT_STATUS  8'h08
`define OFS_INT_MASK    8'h0C
`define OFS_TX_COUNT    8'h10
`define OFS_RX_COUNT    8'h14

// ****************************************
// fields and reset values
// ****************************************
`define CTRL_CLOCKLESS  0
`define STAT_MODE_LSB   0
`define STAT_LOS        2
`define STAT_CLOCKLESS  3
`define INT_LOS_SET     0
`define INT_LOS_CLR     1
`define INT_MODE_CHG    2
`define INT_BITS        3
`define INT_MASK_RESET  3'h0
`define CTRL_RESET      1'h0

`endif

// >>> core/liu_pkg.sv
package liu_pkg;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_LOCAL  = 2'b01,
      MODE_REMOTE = 2'b10,
      MODE_TEST   = 2'b11
   } loop_mode_t;

   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;

   typedef struct packed {
      logic        clk_prev;
      logic        plus_prev;
      logic        minus_prev;
      logic        lin_a_prev;
      logic        lin_b_prev;
      loop_mode_t  mode;
      logic [15:0] los_cnt;
      logic        los;
      logic        out_a;
      logic        out_b;
      logic        rx_p;
      logic        rx_m;
      logic        oe;
      logic        clockless;
      logic [2:0]  int_stat;
      logic [2:0]  int_mask;
      logic        irq;
      logic [15:0] tx_count;
      logic [15:0] rx_count;
      bus_state_t  bus;
      logic        waitreq;
      logic [31:0] rdata;
   } liu_state_t;

endpackage

// >>> core/mark_pair_if.sv
`timescale 1ns/1ps
interface mark_pair_if;
   logic plus;
   logic minus;
   modport drive (output plus, output minus);
   modport take  (input plus, input minus);
endinterface

// >>> core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 7
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next.meta   = pin_in;
      st_next.stable = st_reg.meta;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_sync = st_reg.stable;
endmodule

// >>> core/pulse_stretch.sv
`timescale 1ns/1ps
module pulse_stretch #(
   parameter int CYC = 6
) (
   input  wire logic  mclk,
   input  wire logic  reset,
   mark_pair_if.take  ev,
   output logic       level_plus,
   output logic       level_minus
);
   typedef struct packed {
      logic [1:0]      level;
      logic [1:0][7:0] cnt;
   } stretch_state_t;

   stretch_state_t st_reg;
   stretch_state_t st_next;
   logic [1:0]     ev_bits;

   assign ev_bits = {ev.minus, ev.plus};

   // a new mark restarts the pulse, so back-to-back marks merge
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < 2; i++) begin
         if (ev_bits[i]) begin
            st_next.level[i] = 1'b1;
            st_next.cnt[i]   = 8'(CYC - 1);
         end else if (st_reg.cnt[i] != 8'h00) begin
            st_next.cnt[i] = st_reg.cnt[i] - 8'h01;
         end else begin
            st_next.level[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_plus  = st_reg.level[0];
   assign level_minus = st_reg.level[1];
endmodule

// >>> verification/tb_e1_liu_tx_input_and_loopback.sv
`timescale 1ns/1ps
`include "liu_consts.svh"
module tb_e1_liu_tx_input_and_loopback;
   localparam int PW   = 6;
   localparam int LOSC = 40;

   logic        mclk             = 1'b0;
   logic        reset            = 1'b1;
   logic [7:0]  avs_address      = 8'h00;
   logic        avs_read         = 1'b0;
   logic        avs_write        = 1'b0;
   logic [31:0] avs_writedata    = 32'h0;
   logic [3:0]  avs_byteenable   = 4'hF;
   logic        near_loop_select = 1'b0;
   logic        far_loop_select  = 1'b0;
   logic        line_in_a        = 1'b0;
   logic        line_in_b        = 1'b0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, irq, tx_bit_clock, tx_mark_plus, tx_mark_minus;
   logic        line_out_a, line_out_a_oe, line_out_b, line_out_b_oe;
   logic        rx_mark_plus, rx_mark_plus_oe, rx_mark_minus, rx_mark_minus_oe;
   logic        rx_signal_lost, rx_signal_lost_oe;
   logic [4:0]  oes;
   logic [3:0]  mon, mon_q;
   logic [31:0] rdat;
   int          error_cnt = 0;
   int          compares  = 0;
   int          rises[4]  = '{default: 0};
   int          highs[4]  = '{default: 0};
   int          base[4]   = '{default: 0};
   int          n;
   string       nms[4]    = '{"line_out_a", "line_out_b", "rx_mark_plus", "rx_mark_minus"};

   e1_liu_tx_input_and_loopback #(.LOS_CYCLES(LOSC), .PULSE_CYC(PW)) i_dut (
      .mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .irq, .tx_bit_clock, .tx_mark_plus, .tx_mark_minus,
      .near_loop_select, .far_loop_select, .line_in_a, .line_in_b, .line_out_a,
      .line_out_a_oe, .line_out_b, .line_out_b_oe, .rx_mark_plus, .rx_mark_plus_oe,
      .rx_mark_minus, .rx_mark_minus_oe, .rx_signal_lost, .rx_signal_lost_oe
   );

   term_model i_term (.mclk, .tx_bit_clock, .tx_mark_plus, .tx_mark_minus);

   always #20 mclk = ~mclk;

   assign oes = {line_out_a_oe, line_out_b_oe, rx_mark_plus_oe, rx_mark_minus_oe,
                 rx_signal_lost_oe};
   assign mon = {rx_mark_minus, rx_mark_plus, line_out_b, line_out_a};

   // ****************************************
   // pulse monitor
   // ****************************************
   // counts rises and high cycles so widths are checked without per-pulse timing
   always @(posedge mclk) begin
      mon_q <= mon;
      for (int i = 0; i < 4; i++) begin
         if (mon[i] === 1'b1 && mon_q[i] !== 1'b1) rises[i]++;
         if (mon[i] === 1'b1) highs[i]++;
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // no cycle count assumed; only the watchdog ends a hung access
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_write     <= w;
      avs_read      <= !w;
      avs_address   <= a;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask

   task automatic in_pulse(input logic b);
      @(posedge mclk);
      if (b) line_in_b <= 1'b1;
      else line_in_a <= 1'b1;
      repeat (6) @(posedge mclk);
      line_in_a <= 1'b0;
      line_in_b <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask

   task automatic snap();
      base = rises;
   endtask

   task automatic delta(input int e0, input int e1, input int e2, input int e3);
      int ex[4];
      ex = '{e0, e1, e2, e3};
      repeat (12) @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
         chk(nms[i], ex[i], rises[i] - base[i]);
         chk(nms[i], PW * rises[i], highs[i]);
      end
   endtask

   // selects pass two sync stages and the mode register
   task automatic mode(input logic nr, input logic fr);
      @(posedge mclk);
      near_loop_select <= nr;
      far_loop_select  <= fr;
      repeat (8) @(posedge mclk);
   endtask

   task automatic final_report();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      final_report();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("oe", 5'h1F, oes);
      chk("rx_signal_lost", 1, rx_signal_lost);
      rd_chk(`OFS_CTRL, 0, "ctrl");
      rd_chk(`OFS_STATUS, 32'h4, "status");
      rd_chk(`OFS_INT_MASK, 0, "int_mask");
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      rd_chk(8'h40, 0, "unmapped");
      avs_byteenable <= 4'hE;
      bus(1'b1, `OFS_INT_MASK, 32'h7);
      avs_byteenable <= 4'hF;
      rd_chk(`OFS_INT_MASK, 0, "int_mask lane");
      bus(1'b0, `OFS_INT_STATUS, 0);
      bus(1'b1, `OFS_INT_MASK, 32'h3);
      snap();
      in_pulse(1'b0);
      chk("rx_signal_lost", 0, rx_signal_lost);
      chk("irq", 1, irq);
      rd_chk(`OFS_INT_STATUS, 32'h2, "int_status");
      delta(0, 0, 1, 0);
      snap();
      in_pulse(1'b1);
      delta(0, 0, 0, 1);
      chk("rx_signal_lost", 0, rx_signal_lost);
      n = 0;
      while (rx_signal_lost !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk("los delay", 1, n < LOSC);
      repeat (3) @(posedge mclk);
      chk("irq", 1, irq);
      bus(1'b1, `OFS_INT_MASK, 0);
      repeat (2) @(posedge mclk);
      chk("irq", 0, irq);
      rd_chk(`OFS_INT_STATUS, 32'h1, "int_status");
      snap();
      i_term.send(1'b1, 1'b0, 1'b0);
      i_term.send(1'b0, 1'b1, 1'b0);
      i_term.send(1'b1, 1'b1, 1'b0);
      delta(1, 1, 0, 0);
      bus(1'b1, `OFS_CTRL, 32'h1);
      rd_chk(`OFS_STATUS, 32'hC, "status");
      snap();
      i_term.send(1'b1, 1'b0, 1'b1);
      i_term.send(1'b0, 1'b1, 1'b1);
      delta(1, 1, 0, 0);
      rd_chk(`OFS_TX_COUNT, 32'h4, "tx_count");
      bus(1'b1, `OFS_CTRL, 0);
      mode(1'b1, 1'b0);
      snap();
      i_term.send(1'b1, 1'b0, 1'b0);
      i_term.send(1'b0, 1'b1, 1'b0);
      in_pulse(1'b1);
      delta(1, 1, 1, 1);
      mode(1'b0, 1'b1);
      snap();
      i_term.send(1'b1, 1'b0, 1'b0);
      i_term.send(1'b0, 1'b1, 1'b0);
      in_pulse(1'b0);
      in_pulse(1'b1);
      delta(1, 1, 1, 1);
      mode(1'b1, 1'b1);
      chk("oe", 0, oes);
      bus(1'b0, `OFS_STATUS, 0);
      chk("status mode", 3, rdat & 32'h3);
      mode(1'b0, 1'b0);
      chk("oe", 5'h1F, oes);
      bus(1'b0, `OFS_INT_STATUS, 0);
      chk("int mode change", 32'h4, rdat & 32'h4);
      rd_chk(`OFS_RX_COUNT, 32'h6, "rx_count");
      rd_chk(`OFS_TX_COUNT, 32'h8, "tx_count");
      final_report();
   end
endmodule

// >>> verification/term_model.sv
`timescale 1ns/1ps
// ****************************************
// terminal-side mark source
// ****************************************
module term_model (
   input  wire logic mclk,
   output logic      tx_bit_clock,
   output logic      tx_mark_plus,
   output logic      tx_mark_minus
);
   initial begin
      tx_bit_clock  = 1'b0;
      tx_mark_plus  = 1'b0;
      tx_mark_minus = 1'b0;
   end

   // one symbol of 12 cycles, near the line rate; the clock idles low between symbols
   task automatic send(input logic p, input logic m, input logic cl);
      @(posedge mclk);
      tx_mark_plus  <= p;
      tx_mark_minus <= m;
      tx_bit_clock  <= !cl;
      repeat (6) @(posedge mclk);
      tx_bit_clock <= 1'b0;
      if (cl) begin
         tx_mark_plus  <= 1'b0;
         tx_mark_minus <= 1'b0;
      end
      // rails held past the falling edge for hold margin
      repeat (6) @(posedge mclk);
      tx_mark_plus  <= 1'b0;
      tx_mark_minus <= 1'b0;
   endtask
endmodule
